// *** include/dfd_pkg.sv ***
// package for the drive input function decoder: register map, field layout, codes
// assumes a single 32-bit AHB-Lite slave port and one 200 MHz clock
package dfd_pkg;

  // register byte offsets
  localparam logic [7:0] CtrlOffset     = 8'h00;
  localparam logic [7:0] StatusOffset   = 8'h04;
  localparam logic [7:0] IrqStatOffset  = 8'h08;
  localparam logic [7:0] IrqEnOffset    = 8'h0c;
  localparam logic [7:0] IrqClrOffset   = 8'h10;
  localparam logic [7:0] TripHistOffset = 8'h14;

  // control register layout and reset value
  localparam int          CtrlThermEnBit = 0;
  localparam logic [31:0] CtrlReset      = 32'h0000_0001;

  // status register layout
  localparam int StatTripBit     = 0;
  localparam int StatOutOnBit    = 1;
  localparam int StatDcBrakeBit  = 2;
  localparam int StatHoldBit     = 3;
  localparam int StatLockBit     = 4;
  localparam int StatBypassBit   = 5;
  localparam int StatMotor2Bit   = 6;
  localparam int StatRamp2Bit    = 7;
  localparam int StatStateLsb    = 8;
  localparam int StatSpeedLsb    = 12;
  localparam int StatTripCodeLsb = 16;

  // interrupt event bits
  localparam int IrqWidth     = 5;
  localparam int IrqExtTrip   = 0;
  localparam int IrqHotTrip   = 1;
  localparam int IrqOpenTrip  = 2;
  localparam int IrqHoldStart = 3;
  localparam int IrqReset     = 4;
  localparam logic [IrqWidth-1:0] IrqEnReset = 5'h00;

  // trip codes shown on the display
  localparam logic [7:0] TripNone = 8'h00;
  localparam logic [7:0] TripExt  = 8'h0c;
  localparam logic [7:0] TripHot  = 8'h15;
  localparam logic [7:0] TripOpen = 8'h16;

  // ahb-lite encodings
  localparam logic [1:0] HtransNonseq = 2'h2;
  localparam logic [2:0] HsizeWord    = 3'h2;

  typedef enum logic [1:0] {
    RunStop = 2'h0,
    RunFwd  = 2'h1,
    RunRev  = 2'h3,
    RunJog  = 2'h2
  } dfd_run_t;

endpackage

// *** rtl/dfd_trip_latch.sv ***
// trip latch: holds the first trip cause and a history until the drive reset input
// assumes trip causes are already qualified to one clock domain
`timescale 1ns/1ps
`default_nettype none
module dfd_trip_latch (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       extRise,
  input  wire logic       thermHot,
  input  wire logic       thermOpen,
  input  wire logic       clearTrip,
  output logic            tripActive,
  output logic [7:0]      tripCode,
  output logic [7:0]      tripCount
);

  logic       anyCause;
  logic [7:0] causeCode;

  assign anyCause = extRise | thermHot | thermOpen;

  // external trip has priority when causes coincide
  always_comb begin
    if (extRise) begin
      causeCode = dfd_pkg::TripExt;
    end else if (thermOpen) begin
      causeCode = dfd_pkg::TripOpen;
    end else begin
      causeCode = dfd_pkg::TripHot;
    end
  end

  // first cause is kept; a new cause while tripped leaves the code alone
  always_ff @(posedge clock) begin
    if (!rstn || clearTrip) begin
      tripActive <= 1'b0;
      tripCode   <= dfd_pkg::TripNone;
    end else if (anyCause && !tripActive) begin
      tripActive <= 1'b1;
      tripCode   <= causeCode;
    end
  end

  // history of trip events survives until the drive reset input
  always_ff @(posedge clock) begin
    if (!rstn || clearTrip) begin
      tripCount <= 8'h00;
    end else if (anyCause && !tripActive && tripCount != 8'hff) begin
      tripCount <= tripCount + 8'h01;
    end
  end

endmodule // dfd_trip_latch
`default_nettype wire

// *** rtl/dfd_decoder.sv ***
// top of the drive input function decoder: terminal functions to drive commands
// assumes terminal inputs are debounced and synchronous to clock; ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
module dfd_decoder (
  input  wire logic        clock,
  input  wire logic        rstn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // terminal functions
  input  wire logic        forwardRun,
  input  wire logic        reverseRun,
  input  wire logic        speedSelB0,
  input  wire logic        speedSelB1,
  input  wire logic        speedSelB2,
  input  wire logic        speedSelB3,
  input  wire logic        jogSelect,
  input  wire logic        dcBrakeRequest,
  input  wire logic        secondMotorSelect,
  input  wire logic        secondRampSelect,
  input  wire logic        coastStop,
  input  wire logic        outsideFaultTrip,
  input  wire logic        restartGuard,
  input  wire logic        mainsBypassSelect,
  input  wire logic        paramLock,
  input  wire logic        driveReset,
  input  wire logic        thermOverTemp,
  input  wire logic        thermOpen,
  // drive commands
  output logic             runForward,
  output logic             runReverse,
  output logic             jogRun,
  output logic [3:0]       speedIndex,
  output logic             dcBrakeOn,
  output logic             motorSet2,
  output logic             rampSet2,
  output logic             outputOn,
  output logic             mainsBypass,
  output logic             paramWriteBlock,
  output logic             powerUpReset,
  output logic             tripActive,
  output logic [7:0]       tripCode,
  output logic             irq
);

  // register offset match, shared by the write and read paths
  function automatic logic isReg(input logic [7:0] addr, input logic [7:0] offs);
    return addr == offs;
  endfunction

  // ---------------- bus slave ----------------
  logic       wrPend_q;
  logic [7:0] wrAddr_q;
  logic       accept;
  logic       wrCtrl;
  logic       wrIrqEn;
  logic       wrIrqClr;

  // non-word or unselected transfers are ignored but still answered okay
  assign accept = hsel && hready && htrans == dfd_pkg::HtransNonseq &&
                  hsize == dfd_pkg::HsizeWord;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
    end else begin
      wrPend_q <= accept && hwrite && haddr[31:8] == 24'h000000;
      wrAddr_q <= {haddr[7:2], 2'b00};
    end
  end

  assign wrCtrl   = wrPend_q && isReg(wrAddr_q, dfd_pkg::CtrlOffset);
  assign wrIrqEn  = wrPend_q && isReg(wrAddr_q, dfd_pkg::IrqEnOffset);
  assign wrIrqClr = wrPend_q && isReg(wrAddr_q, dfd_pkg::IrqClrOffset);

  // zero wait states: the slave is ready from the first clock after reset and always okay
  always_ff @(posedge clock) begin
    if (!rstn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ---------------- software registers ----------------
  logic [31:0]                   ctrl_q;
  logic [dfd_pkg::IrqWidth-1:0]  irqEn_q;
  logic [dfd_pkg::IrqWidth-1:0]  irqStat_q;
  logic [dfd_pkg::IrqWidth-1:0]  irqEvent;
  logic                          thermEn;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl_q <= dfd_pkg::CtrlReset;
    end else if (wrCtrl) begin
      ctrl_q <= {31'h0, hwdata[dfd_pkg::CtrlThermEnBit]};
    end
  end

  assign thermEn = ctrl_q[dfd_pkg::CtrlThermEnBit];

  always_ff @(posedge clock) begin
    if (!rstn) begin
      irqEn_q <= dfd_pkg::IrqEnReset;
    end else if (wrIrqEn) begin
      irqEn_q <= hwdata[dfd_pkg::IrqWidth-1:0];
    end
  end

  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge clock) begin
    if (!rstn) begin
      irqStat_q <= '0;
    end else begin
      irqStat_q <= (irqStat_q & ~(wrIrqClr ? hwdata[dfd_pkg::IrqWidth-1:0] : '0)) | irqEvent;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irqStat_q & ~(wrIrqClr ? hwdata[dfd_pkg::IrqWidth-1:0] : '0)) | irqEvent)
               & irqEn_q);
    end
  end

  // ---------------- power-up and reset handling ----------------
  logic faultPrev_q;
  logic faultRise;
  logic firstCycle_q;
  logic runHold_q;
  logic runAsked;
  logic holdStart;
  logic thermHot;
  logic thermLost;
  logic [7:0] tripCount;

  assign runAsked = forwardRun || reverseRun || jogSelect;

  // first cycle after reset release, also re-armed by the reset input
  always_ff @(posedge clock) begin
    if (!rstn) begin
      firstCycle_q <= 1'b1;
    end else begin
      firstCycle_q <= driveReset;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      powerUpReset <= 1'b1;
    end else begin
      powerUpReset <= driveReset;
    end
  end

  // guard sampled at power-up: a standing run command must drop before it counts
  assign holdStart = firstCycle_q && !driveReset && restartGuard && runAsked;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      runHold_q <= 1'b0;
    end else if (holdStart) begin
      runHold_q <= 1'b1;
    end else if (!runAsked) begin
      runHold_q <= 1'b0;
    end
  end

  // edge detector; the previous level is forced high under reset so a held
  // input does not trip on release
  always_ff @(posedge clock) begin
    if (!rstn) begin
      faultPrev_q <= 1'b1;
    end else begin
      faultPrev_q <= outsideFaultTrip;
    end
  end

  assign faultRise = outsideFaultTrip && !faultPrev_q && !driveReset;
  assign thermHot  = thermEn && thermOverTemp && !driveReset;
  assign thermLost = thermEn && thermOpen && !driveReset;

  dfd_trip_latch u_trip (
    .clock      (clock),
    .rstn       (rstn),
    .extRise    (faultRise),
    .thermHot   (thermHot),
    .thermOpen  (thermLost),
    .clearTrip  (driveReset),
    .tripActive (tripActive),
    .tripCode   (tripCode),
    .tripCount  (tripCount)
  );

  always_comb begin
    irqEvent = '0;
    irqEvent[dfd_pkg::IrqExtTrip]   = faultRise;
    irqEvent[dfd_pkg::IrqHotTrip]   = thermHot;
    irqEvent[dfd_pkg::IrqOpenTrip]  = thermLost;
    irqEvent[dfd_pkg::IrqHoldStart] = holdStart;
    irqEvent[dfd_pkg::IrqReset]     = driveReset && !powerUpReset;
  end

  // ---------------- run state ----------------
  // the read word is loaded in the address phase so it stands through the data phase
  logic [7:0]        rdAddr;
  logic [31:0]       statusWord;
  logic [31:0]       readMux;
  dfd_pkg::dfd_run_t runState_q;
  dfd_pkg::dfd_run_t runNext;
  logic              runBlock;
  logic              brakeWindow;

  // a trip cause cuts the run command in its own cycle, not a cycle after the latch
  assign runBlock = tripActive || faultRise || thermHot || thermLost || driveReset ||
                    powerUpReset || runHold_q || holdStart;

  always_comb begin
    if (runBlock) begin
      runNext = dfd_pkg::RunStop;
    end else if (forwardRun && reverseRun) begin
      runNext = dfd_pkg::RunStop;
    end else if (forwardRun) begin
      runNext = dfd_pkg::RunFwd;
    end else if (reverseRun) begin
      runNext = dfd_pkg::RunRev;
    end else if (jogSelect) begin
      runNext = dfd_pkg::RunJog;
    end else begin
      runNext = dfd_pkg::RunStop;
    end
  end

  // direction flags come from their own flops so the power stage sees no decode glitch
  always_ff @(posedge clock) begin
    if (!rstn) begin
      runState_q <= dfd_pkg::RunStop;
      runForward <= 1'b0;
      runReverse <= 1'b0;
      jogRun     <= 1'b0;
    end else begin
      runState_q <= runNext;
      runForward <= runNext == dfd_pkg::RunFwd;
      runReverse <= runNext == dfd_pkg::RunRev;
      jogRun     <= runNext == dfd_pkg::RunJog;
    end
  end

  // braking only while the next run state is stop and the output is not coasting
  assign brakeWindow = runNext == dfd_pkg::RunStop && !coastStop && !tripActive && !driveReset;

  // level functions pass through one flop each
  always_ff @(posedge clock) begin
    if (!rstn) begin
      outputOn        <= 1'b0;
      dcBrakeOn       <= 1'b0;
      speedIndex      <= 4'h0;
      motorSet2       <= 1'b0;
      rampSet2        <= 1'b0;
      mainsBypass     <= 1'b0;
      paramWriteBlock <= 1'b0;
    end else begin
      outputOn        <= runNext != dfd_pkg::RunStop && !coastStop;
      dcBrakeOn       <= dcBrakeRequest && brakeWindow;
      speedIndex      <= {speedSelB3, speedSelB2, speedSelB1, speedSelB0};
      motorSet2       <= secondMotorSelect;
      rampSet2        <= secondRampSelect;
      mainsBypass     <= mainsBypassSelect;
      paramWriteBlock <= paramLock;
    end
  end

  assign rdAddr = {haddr[7:2], 2'b00};

  always_comb begin
    statusWord = 32'h0;
    statusWord[dfd_pkg::StatTripBit]    = tripActive;
    statusWord[dfd_pkg::StatOutOnBit]   = outputOn;
    statusWord[dfd_pkg::StatDcBrakeBit] = dcBrakeOn;
    statusWord[dfd_pkg::StatHoldBit]    = runHold_q;
    statusWord[dfd_pkg::StatLockBit]    = paramWriteBlock;
    statusWord[dfd_pkg::StatBypassBit]  = mainsBypass;
    statusWord[dfd_pkg::StatMotor2Bit]  = motorSet2;
    statusWord[dfd_pkg::StatRamp2Bit]   = rampSet2;
    statusWord[dfd_pkg::StatStateLsb +: 2]    = runState_q;
    statusWord[dfd_pkg::StatSpeedLsb +: 4]    = speedIndex;
    statusWord[dfd_pkg::StatTripCodeLsb +: 8] = tripCode;
  end

  always_comb begin
    readMux = 32'h0;
    if (isReg(rdAddr, dfd_pkg::CtrlOffset)) begin
      readMux = ctrl_q;
    end else if (isReg(rdAddr, dfd_pkg::StatusOffset)) begin
      readMux = statusWord;
    end else if (isReg(rdAddr, dfd_pkg::IrqStatOffset)) begin
      readMux = 32'(irqStat_q);
    end else if (isReg(rdAddr, dfd_pkg::IrqEnOffset)) begin
      readMux = 32'(irqEn_q);
    end else if (isReg(rdAddr, dfd_pkg::TripHistOffset)) begin
      readMux = {24'h000000, tripCount};
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      hrdata <= 32'h0;
    end else if (accept && !hwrite) begin
      hrdata <= (haddr[31:8] == 24'h000000) ? readMux : 32'h0;
    end
  end
endmodule // dfd_decoder
`default_nettype wire

// *** bench/dfd_checker_properties.sv ***
// checker: terminal-to-command relations of the input function decoder
// assumes terminal inputs reach the commands within three clocks of a change
`timescale 1ns/1ps
`default_nettype none
module dfd_checker (
  input wire logic clock,
  input wire logic rstn,
  input wire logic forwardRun,
  input wire logic reverseRun,
  input wire logic runForward,
  input wire logic runReverse,
  input wire logic coastStop,
  input wire logic outputOn,
  input wire logic outsideFaultTrip,
  input wire logic driveReset,
  input wire logic tripActive,
  input wire logic powerUpReset,
  input wire logic paramLock,
  input wire logic paramWriteBlock
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_fwd_off; !forwardRun [*3] |-> !runForward; endproperty
  a_fwd_off: assert property (p_fwd_off) else $error("forward run without input");
  property p_rev_off; !reverseRun [*3] |-> !runReverse; endproperty
  a_rev_off: assert property (p_rev_off) else $error("reverse run without input");
  property p_both; (forwardRun && reverseRun) [*3] |-> !runForward && !runReverse; endproperty
  a_both: assert property (p_both) else $error("run with both directions");
  property p_coast; coastStop [*3] |-> !outputOn; endproperty
  a_coast: assert property (p_coast) else $error("output on during coast");
  property p_ext;
    $rose(outsideFaultTrip) && !driveReset ##1 !driveReset [*3] |-> tripActive;
  endproperty
  a_ext: assert property (p_ext) else $error("external rise not latched");
  property p_hold; $fell(tripActive) |-> driveReset || $past(driveReset) || $past(driveReset, 2);
  endproperty
  a_hold: assert property (p_hold) else $error("trip dropped without reset");
  property p_trip; tripActive [*3] |-> !runForward && !runReverse; endproperty
  a_trip: assert property (p_trip) else $error("run while tripped");
  property p_rst; driveReset [*3] |-> !tripActive && !outputOn && powerUpReset; endproperty
  a_rst: assert property (p_rst) else $error("reset input not honoured");
  property p_lock; $stable(paramLock) [*3] |-> paramWriteBlock == paramLock; endproperty
  a_lock: assert property (p_lock) else $error("lock not followed");
endmodule // dfd_checker
bind dfd_decoder dfd_checker u_chk (.*);
`default_nettype wire

// *** bench/dfd_terminal_model.sv ***
// field switches: terminal levels change one clock after the bench asks
// assumes switches are already debounced, so no bounce is modelled
`timescale 1ns/1ps
`default_nettype none
module dfd_terminal_model (
  input  wire logic        clock,
  input  wire logic [17:0] setTerm,
  output logic      [17:0] term
);
  always_ff @(posedge clock) begin
    term <= setTerm;
  end
endmodule // dfd_terminal_model
`default_nettype wire

// *** bench/drive_input_function_decoder_tb.sv ***
// testbench: terminal scenarios and register access for the input function decoder
// assumes commands settle within six clocks of a terminal change
`timescale 1ns/1ps
`default_nettype none
module drive_input_function_decoder_tb;
  logic        clock, rstn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [17:0] sw, term;
  logic        runForward, runReverse, jogRun, dcBrakeOn, motorSet2, rampSet2, outputOn;
  logic        mainsBypass, paramWriteBlock, powerUpReset, tripActive;
  logic [3:0]  speedIndex;
  logic [7:0]  tripCode;
  int          failures = 0, checks = 0, cyc = 0;
  assign hready = hreadyout;
  dfd_terminal_model u_sw (.clock(clock), .setTerm(sw), .term(term));
  dfd_decoder DUT (.*, .forwardRun(term[0]), .reverseRun(term[1]), .speedSelB0(term[2]),
    .speedSelB1(term[3]), .speedSelB2(term[4]), .speedSelB3(term[5]), .jogSelect(term[6]),
    .dcBrakeRequest(term[7]), .secondMotorSelect(term[8]), .secondRampSelect(term[9]),
    .coastStop(term[10]), .outsideFaultTrip(term[11]), .restartGuard(term[12]),
    .mainsBypassSelect(term[13]), .paramLock(term[14]), .driveReset(term[15]),
    .thermOverTemp(term[16]), .thermOpen(term[17]));
  task automatic results;
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one whole-word single transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= dfd_pkg::HtransNonseq;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask
  task automatic put(input logic [17:0] v);
    @(posedge clock);
    sw <= v;
    repeat (6) @(posedge clock);
  endtask
  task automatic t_run;
    for (int i = 0; i < 4; i++) begin
      put(18'(i));
      chk("runForward", 32'(i == 1), 32'(runForward));
      chk("runReverse", 32'(i == 2), 32'(runReverse));
    end
  endtask
  task automatic t_speed;
    for (int i = 0; i < 16; i++) begin
      put(18'(i) << 2);
      chk("speedIndex", 32'(i), 32'(speedIndex));
    end
  endtask
  task automatic t_levels;
    int b[5] = '{6, 8, 9, 13, 14};
    for (int k = 0; k < 5; k++) begin
      put(18'h1 << b[k]);
      chk("levels", 32'h1 << k, {27'h0, paramWriteBlock, mainsBypass, rampSet2, motorSet2, jogRun});
    end
  endtask
  task automatic t_coast;
    put(18'h401);
    chk("coast", 32'h0, 32'(outputOn));
    put(18'h1);
    chk("coast", 32'h1, 32'(outputOn));
    put(18'h80);
    chk("dcBrakeOn", 32'h1, 32'(dcBrakeOn));
    put(18'h81);
    chk("dcBrakeOn", 32'h0, 32'(dcBrakeOn));
  endtask
  task automatic t_ext;
    ahb(1'b0, dfd_pkg::IrqEnOffset, 32'h0);
    chk("irqEn", 32'(dfd_pkg::IrqEnReset), rd);
    put(18'h800);
    chk("trip", 32'h1, 32'(tripActive));
    chk("tripCode", 32'(dfd_pkg::TripExt), 32'(tripCode));
    chk("masked", 32'h0, 32'(irq));
    ahb(1'b0, dfd_pkg::IrqStatOffset, 32'h0);
    chk("irqStat", 32'h1, 32'(rd[dfd_pkg::IrqExtTrip]));
    ahb(1'b1, dfd_pkg::IrqEnOffset, 32'h1 << dfd_pkg::IrqExtTrip);
    repeat (2) @(posedge clock);
    chk("irq", 32'h1, 32'(irq));
    put(18'h1);
    chk("trip", 32'h1, 32'(tripActive));
    chk("runForward", 32'h0, 32'(runForward));
    ahb(1'b1, dfd_pkg::IrqClrOffset, 32'h1 << dfd_pkg::IrqExtTrip);
    repeat (2) @(posedge clock);
    chk("irq", 32'h0, 32'(irq));
    ahb(1'b0, dfd_pkg::TripHistOffset, 32'h0);
    chk("tripHist", 32'h1, rd);
    ahb(1'b0, 8'h3c, 32'h0);
    chk("unmapped", 32'h0, rd);
    put(18'h8000);
    chk("trip", 32'h0, 32'(tripActive));
    chk("powerUpReset", 32'h1, 32'(powerUpReset));
    put(18'h0);
  endtask
  task automatic t_therm;
    for (int j = 0; j < 2; j++) begin
      put(18'h1 | (18'h10000 << j));
      chk("trip", 32'h1, 32'(tripActive));
      chk("outputOn", 32'h0, 32'(outputOn));
      chk("tripCode", 32'(j ? dfd_pkg::TripOpen : dfd_pkg::TripHot), 32'(tripCode));
      put(18'h8000);
      put(18'h0);
    end
  endtask
  task automatic t_guard;
    put(18'h1001);
    rstn <= 1'b0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    repeat (6) @(posedge clock);
    chk("runForward", 32'h0, 32'(runForward));
    put(18'h0);
  endtask
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      results;
    end
  end
  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hsize = dfd_pkg::HsizeWord;
    hwdata = 32'h0;
    sw = 18'h0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    ahb(1'b0, dfd_pkg::CtrlOffset, 32'h0);
    chk("ctrl", dfd_pkg::CtrlReset, rd);
    t_run;
    t_speed;
    t_levels;
    t_coast;
    t_ext;
    t_therm;
    t_guard;
    results;
  end
endmodule // drive_input_function_decoder_tb
`default_nettype wire
